//--- cip_pkg.sv
// constants, types and register map of the current and input protection block
// Function
// - one 12-bit converter samples all six sense channels
// - zero quick threshold disables that comparator
// - per-stage balance adjustment added to ramp threshold
// - raise lowest, lower highest by same step
// - adjustments always stay positive
// - fault pin high: interrupt, rail 0 outputs off
// - fault pin as sequencing pin is ignored
// - per-comparator threshold, 64 steps, 31mV to 2V
// - comparator trip drives rail outputs low
// - scale, sum rail stages, compare averaged limit
// - averaged over-current takes configured action
// - detect within sample interval plus filter lag
// - foldback lowers voltage while above low limit
// - below low limit, shut down if configured
// - mux lsb low voltage, high current
// - mux lsb is temperature select lsb
// - input compared to over and under limits
// - turn-on/off lockout; below off, soft-stop
// - input undervoltage action: continue, delay, shutdown
// - one rail converted every 200 microseconds
// - filter time constant about 3.5 intervals
package cip_pkg;
   localparam int NCH  = 6;
   localparam int NRL  = 4;
   localparam int ADW  = 12;
   localparam int CLK_HZ       = 20_000_000;
   localparam int RAIL_US      = 200;
   localparam int RAIL_CYC     = (CLK_HZ / 1_000_000) * RAIL_US;
   localparam int FAULT_US     = 14;
   localparam int FAULT_CYC    = (CLK_HZ / 1_000_000) * FAULT_US;
   localparam int FILT_SH      = 2;
   localparam int THR_W        = 6;
   localparam logic [11:0] ADDR_CTRL   = 12'h0000;
   localparam logic [11:0] ADDR_QTHR   = 12'h0004;
   localparam logic [11:0] ADDR_MAP    = 12'h0008;
   localparam logic [11:0] ADDR_GAIN   = 12'h000c;
   localparam logic [11:0] ADDR_OFFS   = 12'h0010;
   localparam logic [11:0] ADDR_OCLIM  = 12'h0014;
   localparam logic [11:0] ADDR_LVLIM  = 12'h0018;
   localparam logic [11:0] ADDR_VINLIM = 12'h001c;
   localparam logic [11:0] ADDR_LOCK   = 12'h0020;
   localparam logic [11:0] ADDR_ISCL   = 12'h0024;
   localparam logic [11:0] ADDR_STAT   = 12'h0028;
   localparam logic [11:0] ADDR_RAILI  = 12'h002c;
   localparam logic [11:0] ADDR_ADJ    = 12'h0030;
   localparam logic [11:0] ADDR_INPUT  = 12'h0034;
   localparam logic [2:0]  ACT_CONT    = 3'h0;
   localparam logic [2:0]  ACT_DELAY   = 3'h1;
   localparam logic [2:0]  ACT_SHUT    = 3'h2;
   localparam logic [2:0]  ACT_FOLD    = 3'h3;
   localparam logic [7:0]  ADJ_MID     = 8'h80;
   localparam logic [7:0]  ADJ_MIN     = 8'h01;
   localparam logic [7:0]  ADJ_MAX     = 8'hfe;
   typedef enum logic [1:0] {CIP_REQ = 2'b00, CIP_WAIT = 2'b01, CIP_CALC = 2'b11} cip_seq_t;
   typedef struct packed {
      logic        req;
      logic [2:0]  chan;
   } cip_adc_req_t;
   typedef struct packed {
      logic        valid;
      logic [11:0] data;
   } cip_adc_rsp_t;
endpackage

//--- cip_top.sv
// current sensing, balancing, over-current and input lockout logic
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module cip_top (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  clk_en,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   output cip_pkg::cip_adc_req_t      adc_req,
   input  wire cip_pkg::cip_adc_rsp_t adc_rsp,
   input  wire logic [3:0]            quick_cmp_trip,
   output logic [3:0][5:0]            quick_overcurrent_threshold,
   output logic [3:0]                 quick_cmp_enable,
   input  wire logic                  fault_pin,
   input  wire logic [3:0]            rail_vout_low,
   output logic [5:0]                 pulse_width_output_enable,
   output logic [5:0]                 sync_rectifier_enable,
   output logic [5:0][7:0]            balance_adjust,
   output logic [3:0]                 foldback_active,
   output logic [3:0]                 soft_stop_req,
   output logic                       fault_irq,
   output logic                       monitor_mux_select_lsb
);
   // ---- configuration registers ----
   logic [31:0] ctrl_ff, qthr_ff, map_ff, gain_ff, offs_ff, oclim_ff, lvlim_ff, vinlim_ff, lock_ff, iscl_ff;
   logic [31:0] nxt_ctrl, nxt_qthr, nxt_map, nxt_gain, nxt_offs, nxt_oclim, nxt_lvlim, nxt_vinlim, nxt_lock, nxt_iscl;
   logic [31:0] prdata_ff, nxt_prdata;
   logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
   // ctrl: [3:0] rail enable, [4] fault pin is sequencing pin, [7:5] avg action,
   // [10:8] low-voltage action, [13:11] input uv action
   logic [2:0] oc_act, lv_act, uv_act;
   assign oc_act = ctrl_ff[7:5];
   assign lv_act = ctrl_ff[10:8];
   assign uv_act = ctrl_ff[13:11];

   // ---- state ----
   cip_pkg::cip_seq_t seq_ff, nxt_seq;
   logic [12:0] tmr_ff, nxt_tmr;
   logic [2:0]  chan_ff, nxt_chan;
   logic [1:0]  rail_ff, nxt_rail;
   logic [5:0][11:0] samp_ff, nxt_samp;
   logic [3:0][15:0] filt_ff, nxt_filt;
   logic [5:0][7:0]  adj_ff, nxt_adj;
   logic [11:0] vin_ff, nxt_vin, iin_ff, nxt_iin;
   logic        mux_ff, nxt_mux;
   logic [3:0]  fold_ff, nxt_fold, stop_ff, nxt_stop, oc_ff, nxt_oc;
   logic [5:0]  off_ff, nxt_off;
   logic [3:0]  qf_ff, nxt_qf;
   logic        pf_ff, nxt_pf, ovf_ff, nxt_ovf, uvf_ff, nxt_uvf, lock_st_ff, nxt_lock_st;
   logic        fs1_ff, fs2_ff, fs3_ff;
   logic [9:0]  fcnt_ff, nxt_fcnt;
   logic        freq_ff, nxt_freq;
   logic [3:0]  q1_ff, q2_ff, lv1_ff, lv2_ff;
   logic [5:0]  pwe_ff, sre_ff;

   // stage to rail map: two bits per stage
   function automatic logic [1:0] stage_rail(input logic [31:0] m, input int s);
      stage_rail = m[2*s +: 2];
   endfunction

   function automatic logic [5:0] rail_stages(input logic [31:0] m, input logic [1:0] r);
      logic [5:0] v;
      v = '0;
      for (int s = 0; s < cip_pkg::NCH; s++) v[s] = (stage_rail(m, s) == r);
      rail_stages = v;
   endfunction

   // ---- APB slave: zero wait state, registered answer ----
   logic acc, wr;
   assign acc = psel && !penable;
   assign wr  = psel && penable && pwrite && pready_ff;
   always_comb begin
      nxt_ctrl = ctrl_ff; nxt_qthr = qthr_ff; nxt_map = map_ff; nxt_gain = gain_ff; nxt_offs = offs_ff;
      nxt_oclim = oclim_ff; nxt_lvlim = lvlim_ff; nxt_vinlim = vinlim_ff; nxt_lock = lock_ff; nxt_iscl = iscl_ff;
      nxt_prdata = prdata_ff;
      nxt_pready = 1'b0;
      nxt_pslverr = 1'b0;
      if (acc) begin
         nxt_pready = 1'b1;
         nxt_prdata = '0;
         unique case (paddr)
            cip_pkg::ADDR_CTRL:   nxt_prdata = ctrl_ff;
            cip_pkg::ADDR_QTHR:   nxt_prdata = qthr_ff;
            cip_pkg::ADDR_MAP:    nxt_prdata = map_ff;
            cip_pkg::ADDR_GAIN:   nxt_prdata = gain_ff;
            cip_pkg::ADDR_OFFS:   nxt_prdata = offs_ff;
            cip_pkg::ADDR_OCLIM:  nxt_prdata = oclim_ff;
            cip_pkg::ADDR_LVLIM:  nxt_prdata = lvlim_ff;
            cip_pkg::ADDR_VINLIM: nxt_prdata = vinlim_ff;
            cip_pkg::ADDR_LOCK:   nxt_prdata = lock_ff;
            cip_pkg::ADDR_ISCL:   nxt_prdata = iscl_ff;
            cip_pkg::ADDR_STAT:   nxt_prdata = {12'h000, lock_st_ff, uvf_ff, ovf_ff, pf_ff, qf_ff, oc_ff, fold_ff, stop_ff};
            cip_pkg::ADDR_RAILI:  nxt_prdata = {filt_ff[1], filt_ff[0]};
            cip_pkg::ADDR_ADJ:    nxt_prdata = {adj_ff[3], adj_ff[2], adj_ff[1], adj_ff[0]};
            cip_pkg::ADDR_INPUT:  nxt_prdata = {4'h0, iin_ff, 4'h0, vin_ff};
            default:              nxt_pslverr = 1'b1;
         endcase
      end
      if (wr) begin
         unique case (paddr)
            cip_pkg::ADDR_CTRL:   nxt_ctrl = pwdata;
            cip_pkg::ADDR_QTHR:   nxt_qthr = pwdata;
            cip_pkg::ADDR_MAP:    nxt_map = pwdata;
            cip_pkg::ADDR_GAIN:   nxt_gain = pwdata;
            cip_pkg::ADDR_OFFS:   nxt_offs = pwdata;
            cip_pkg::ADDR_OCLIM:  nxt_oclim = pwdata;
            cip_pkg::ADDR_LVLIM:  nxt_lvlim = pwdata;
            cip_pkg::ADDR_VINLIM: nxt_vinlim = pwdata;
            cip_pkg::ADDR_LOCK:   nxt_lock = pwdata;
            cip_pkg::ADDR_ISCL:   nxt_iscl = pwdata;
            default:              nxt_pslverr = 1'b0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= '0; qthr_ff <= '0; map_ff <= '0; gain_ff <= '0; offs_ff <= '0;
         oclim_ff <= '0; lvlim_ff <= '0; vinlim_ff <= '0; lock_ff <= '0; iscl_ff <= '0;
         prdata_ff <= '0; pready_ff <= 1'b0; pslverr_ff <= 1'b0;
      end else if (clk_en) begin
         ctrl_ff <= nxt_ctrl; qthr_ff <= nxt_qthr; map_ff <= nxt_map; gain_ff <= nxt_gain; offs_ff <= nxt_offs;
         oclim_ff <= nxt_oclim; lvlim_ff <= nxt_lvlim; vinlim_ff <= nxt_vinlim; lock_ff <= nxt_lock;
         iscl_ff <= nxt_iscl; prdata_ff <= nxt_prdata; pready_ff <= nxt_pready; pslverr_ff <= nxt_pslverr;
      end
   end

   // ---- pin synchronisers ----
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs1_ff <= 1'b0; fs2_ff <= 1'b0; q1_ff <= '0; q2_ff <= '0;
         lv1_ff <= '0; lv2_ff <= '0;
      end else if (clk_en) begin
         fs1_ff <= fault_pin; fs2_ff <= fs1_ff; q1_ff <= quick_cmp_trip; q2_ff <= q1_ff;
         lv1_ff <= rail_vout_low; lv2_ff <= lv1_ff;
      end
   end

   // ---- converter sequencer, filter, balancing, limits ----
   logic [15:0] rail_sum;
   logic [23:0] scaled;
   logic [5:0]  in_rail;
   logic [11:0] vscaled;
   int hi, lo;
   always_comb begin
      nxt_seq = seq_ff; nxt_tmr = tmr_ff; nxt_chan = chan_ff; nxt_rail = rail_ff; nxt_samp = samp_ff;
      nxt_filt = filt_ff; nxt_adj = adj_ff; nxt_vin = vin_ff; nxt_iin = iin_ff; nxt_mux = mux_ff;
      nxt_fold = fold_ff; nxt_stop = stop_ff; nxt_oc = oc_ff; nxt_uvf = uvf_ff; nxt_ovf = ovf_ff;
      nxt_lock_st = lock_st_ff;
      rail_sum = '0; scaled = '0; hi = 0; lo = 0; vscaled = '0;
      in_rail = rail_stages(map_ff, rail_ff);
      nxt_tmr = (tmr_ff == 13'(cip_pkg::RAIL_CYC - 1)) ? '0 : tmr_ff + 13'd1;
      unique case (seq_ff)
         cip_pkg::CIP_REQ: begin
            if (tmr_ff == '0) begin
               nxt_chan = '0;
               nxt_seq = cip_pkg::CIP_WAIT;
            end
         end
         cip_pkg::CIP_WAIT: begin
            if (adc_rsp.valid) begin
               if (chan_ff < 3'(cip_pkg::NCH)) nxt_samp[chan_ff] = adc_rsp.data;
               else if (!mux_ff) nxt_vin = adc_rsp.data;
               else nxt_iin = adc_rsp.data;
               if (chan_ff == 3'(cip_pkg::NCH)) nxt_seq = cip_pkg::CIP_CALC;
               else nxt_chan = chan_ff + 3'd1;
            end
         end
         cip_pkg::CIP_CALC: begin
            // gain/offset per stage, summed over the rail
            for (int s = 0; s < cip_pkg::NCH; s++) begin
               scaled = 24'(samp_ff[s]) * 24'(gain_ff[11:0]);
               if (in_rail[s]) rail_sum = rail_sum + 16'(scaled[19:8]) + offs_ff[15:0];
            end
            // filtered once per visit of this rail
            nxt_filt[rail_ff] = filt_ff[rail_ff] + 16'((32'(rail_sum) - 32'(filt_ff[rail_ff])) >>> cip_pkg::FILT_SH);
            // pick the extremes among the rail's stages
            for (int s = 0; s < cip_pkg::NCH; s++) begin
               if (in_rail[s] && (!in_rail[hi] || samp_ff[s] > samp_ff[hi])) hi = s;
               if (in_rail[s] && (!in_rail[lo] || samp_ff[s] < samp_ff[lo])) lo = s;
            end
            // the step is skipped if either end would leave range
            if (hi != lo && adj_ff[hi] > cip_pkg::ADJ_MIN && adj_ff[lo] < cip_pkg::ADJ_MAX) begin
               nxt_adj[hi] = adj_ff[hi] - 8'd1;
               nxt_adj[lo] = adj_ff[lo] + 8'd1;
            end
            // limit checked on the same visit the filter updates
            if (nxt_filt[rail_ff] > oclim_ff[15:0] && ctrl_ff[rail_ff]) begin
               nxt_oc[rail_ff] = 1'b1;
               nxt_fold[rail_ff] = (oc_act == cip_pkg::ACT_FOLD);
               if (oc_act == cip_pkg::ACT_SHUT) nxt_stop[rail_ff] = 1'b1;
            end else nxt_fold[rail_ff] = 1'b0;
            vscaled = 12'((24'(vin_ff) * 24'(iscl_ff[27:16])) >> 8);
            nxt_iin = iin_ff;
            nxt_ovf = vscaled > vinlim_ff[27:16];
            nxt_uvf = vscaled < vinlim_ff[11:0];
            // lockout with turn-on / turn-off hysteresis
            if (vscaled < lock_ff[11:0]) nxt_lock_st = 1'b1;
            else if (vscaled > lock_ff[27:16]) nxt_lock_st = 1'b0;
            nxt_mux = !mux_ff;
            nxt_rail = rail_ff + 2'd1;
            nxt_seq = cip_pkg::CIP_REQ;
         end
         default: nxt_seq = cip_pkg::CIP_REQ;
      endcase
   end

   // ---- shutdown and fault pin timing ----
   logic [3:0] rail_kill;
   always_comb begin
      nxt_qf = qf_ff; nxt_pf = pf_ff; nxt_fcnt = fcnt_ff; nxt_freq = freq_ff; nxt_off = '0;
      rail_kill = '0;
      for (int r = 0; r < cip_pkg::NRL; r++) begin
         if (q2_ff[r] && qthr_ff[6*r +: 6] != '0) nxt_qf[r] = 1'b1;
         if (oc_ff[r] && oc_act == cip_pkg::ACT_SHUT) rail_kill[r] = 1'b1;
         if (fold_ff[r] && lv2_ff[r] && lv_act == cip_pkg::ACT_SHUT) rail_kill[r] = 1'b1;
         if (qf_ff[r]) rail_kill[r] = 1'b1;
      end
      if (fs2_ff && !ctrl_ff[4] && !freq_ff) begin
         nxt_pf = 1'b1;
         nxt_freq = 1'b1;
         nxt_fcnt = 10'(cip_pkg::FAULT_CYC - 1);
      end else if (freq_ff) begin
         if (fcnt_ff == '0) nxt_freq = 1'b0;
         else nxt_fcnt = fcnt_ff - 10'd1;
      end
      // fault pin owns rail 0; the outputs drop before the 14 us budget ends
      if (pf_ff) rail_kill[0] = 1'b1;
      for (int s = 0; s < cip_pkg::NCH; s++) begin
         nxt_off[s] = rail_kill[stage_rail(map_ff, s)] || !ctrl_ff[stage_rail(map_ff, s)];
         if (uvf_ff && uv_act == cip_pkg::ACT_SHUT) nxt_off[s] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_ff <= cip_pkg::CIP_REQ; tmr_ff <= '0; chan_ff <= '0; rail_ff <= '0; samp_ff <= '0; filt_ff <= '0;
         adj_ff <= {cip_pkg::NCH{cip_pkg::ADJ_MID}};
         vin_ff <= '0; iin_ff <= '0; mux_ff <= 1'b0; fold_ff <= '0; stop_ff <= '0; oc_ff <= '0;
         uvf_ff <= 1'b0; ovf_ff <= 1'b0; lock_st_ff <= 1'b1; qf_ff <= '0; pf_ff <= 1'b0;
         fcnt_ff <= '0; freq_ff <= 1'b0; off_ff <= '1; pwe_ff <= '0; sre_ff <= '0;
      end else if (clk_en) begin
         seq_ff <= nxt_seq; tmr_ff <= nxt_tmr; chan_ff <= nxt_chan; rail_ff <= nxt_rail; samp_ff <= nxt_samp;
         filt_ff <= nxt_filt; adj_ff <= nxt_adj; vin_ff <= nxt_vin; iin_ff <= nxt_iin; mux_ff <= nxt_mux;
         fold_ff <= nxt_fold; stop_ff <= nxt_stop; oc_ff <= nxt_oc; uvf_ff <= nxt_uvf; ovf_ff <= nxt_ovf;
         lock_st_ff <= nxt_lock_st; qf_ff <= nxt_qf; pf_ff <= nxt_pf; fcnt_ff <= nxt_fcnt; freq_ff <= nxt_freq;
         off_ff <= nxt_off; pwe_ff <= ~nxt_off; sre_ff <= ~nxt_off;
      end
   end

   // soft stop: averaged over-current shutdown, lockout, or undervoltage with any action but shutdown
   logic [3:0] stop_ff2;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) stop_ff2 <= '0;
      else if (clk_en) stop_ff2 <= stop_ff | {4{lock_st_ff}} | {4{uvf_ff && uv_act != cip_pkg::ACT_SHUT}};
   end

   logic [3:0] qen_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) qen_ff <= '0;
      else if (clk_en) for (int r = 0; r < cip_pkg::NRL; r++) qen_ff[r] <= qthr_ff[6*r +: 6] != '0;
   end

   logic req_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) req_ff <= 1'b0;
      else if (clk_en) req_ff <= (nxt_seq == cip_pkg::CIP_WAIT) && (seq_ff != cip_pkg::CIP_WAIT || adc_rsp.valid);
   end

   logic [3:0][5:0] qthr_o_ff;
   logic [2:0] chan_o_ff;
   logic irq_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qthr_o_ff <= '0; chan_o_ff <= '0; irq_ff <= 1'b0;
      end else if (clk_en) begin
         qthr_o_ff <= qthr_ff[23:0];
         chan_o_ff <= nxt_chan;
         irq_ff <= nxt_pf;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign adc_req = '{req: req_ff, chan: chan_o_ff};
   assign quick_overcurrent_threshold = qthr_o_ff;
   assign quick_cmp_enable = qen_ff;
   assign pulse_width_output_enable = pwe_ff;
   assign sync_rectifier_enable = sre_ff;
   assign balance_adjust = adj_ff;
   assign foldback_active = fold_ff;
   assign soft_stop_req = stop_ff2;
   assign fault_irq = irq_ff;
   assign monitor_mux_select_lsb = mux_ff;
endmodule
`default_nettype wire

//--- cip_asserts.sv
// port-level assertion checker for the protection block
`timescale 1ns/10ps
`default_nettype none
module cip_asserts (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  clk_en,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire cip_pkg::cip_adc_req_t adc_req,
   input wire cip_pkg::cip_adc_rsp_t adc_rsp,
   input wire logic [3:0]            quick_cmp_trip,
   input wire logic [3:0][5:0]       quick_overcurrent_threshold,
   input wire logic [3:0]            quick_cmp_enable,
   input wire logic                  fault_pin,
   input wire logic [5:0]            pulse_width_output_enable,
   input wire logic [5:0]            sync_rectifier_enable,
   input wire logic [5:0][7:0]       balance_adjust,
   input wire logic                  fault_irq
);
   logic [11:0] map_ff, nxt_map;
   logic        seq_ff, nxt_seq, seen_ff, nxt_seen, wr_w, req0_w, adj_ok;
   logic [15:0] cnt_ff, nxt_cnt;
   logic [5:0]  on_w, rail0_w, trip_w;
   logic [3:0]  zero_w;
   // shadow of the stage map and pin mode, so rail ownership is known at the ports
   always_comb begin
      wr_w = psel && penable && pready && pwrite;
      req0_w = adc_req.req && adc_req.chan == 3'h0;
      nxt_map = (wr_w && paddr == cip_pkg::ADDR_MAP) ? pwdata[11:0] : map_ff;
      nxt_seq = (wr_w && paddr == cip_pkg::ADDR_CTRL) ? pwdata[4] : seq_ff;
      nxt_seen = seen_ff || req0_w;
      nxt_cnt = req0_w ? 16'h0001 : cnt_ff + {15'h0000, cnt_ff != 16'hffff};
      on_w = pulse_width_output_enable | sync_rectifier_enable;
      adj_ok = 1'b1;
      for (int s = 0; s < 6; s++) begin
         rail0_w[s] = map_ff[2*s+:2] == 2'h0;
         trip_w[s] = quick_cmp_trip[map_ff[2*s+:2]] && quick_cmp_enable[map_ff[2*s+:2]];
         adj_ok = adj_ok && balance_adjust[s] != 8'h00;
      end
      for (int i = 0; i < 4; i++) zero_w[i] = quick_overcurrent_threshold[i] == 6'h00;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         map_ff <= 12'h000;
         seq_ff <= 1'b0;
         seen_ff <= 1'b0;
         cnt_ff <= 16'h0000;
      end else begin
         map_ff <= nxt_map;
         seq_ff <= nxt_seq;
         seen_ff <= nxt_seen;
         cnt_ff <= nxt_cnt;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable && clk_en |=> pready)
      else $error("no ready one cycle after setup");
   a_unmapped_error: assert property (psel && penable && pready && paddr > cip_pkg::ADDR_INPUT
      |-> pslverr && (pwrite || prdata == 32'h0000_0000)) else $error("unmapped access not refused");
   a_quick_zero_off: assert property ($stable(quick_overcurrent_threshold) |-> quick_cmp_enable == ~zero_w)
      else $error("comparator enable does not follow threshold");
   a_adjust_positive: assert property (adj_ok)
      else $error("balance adjustment reached zero");
   a_fault_rail_off: assert property (fault_pin && !seq_ff |-> ##[1:280] (fault_irq && (on_w & rail0_w) == 6'h00))
      else $error("fault pin did not stop rail 0 in time");
   a_seq_no_fault: assert property (seq_ff && $past(seq_ff, 3) && !fault_irq |=> !fault_irq)
      else $error("sequencing pin raised a fault");
   a_trip_stage_off: assert property (trip_w != 6'h00 |-> ##[1:6] (on_w & trip_w) == 6'h00)
      else $error("comparator trip left stages running");
   a_conv_one_pending: assert property (adc_req.req |=> !adc_req.req until adc_rsp.valid)
      else $error("conversion requested before result");
   a_rail_period: assert property (req0_w && seen_ff |-> cnt_ff == 16'h0fa0)
      else $error("conversion period is not 4000 cycles");
endmodule
bind cip_top cip_asserts u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .adc_req, .adc_rsp, .quick_cmp_trip, .quick_overcurrent_threshold, .quick_cmp_enable,
   .fault_pin, .pulse_width_output_enable, .sync_rectifier_enable, .balance_adjust, .fault_irq);
`default_nettype wire

//--- cip_adc_model.sv
// behavioural sense converter with the external input voltage/current mux
`timescale 1ns/10ps
`default_nettype none
module cip_adc_model (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire cip_pkg::cip_adc_req_t adc_req,
   input wire logic                  monitor_mux_select_lsb,
   input wire logic [5:0][11:0]      sense,
   input wire logic [11:0]           vin,
   input wire logic [11:0]           iin,
   output cip_pkg::cip_adc_rsp_t     adc_rsp
);
   logic [2:0]  chan;
   logic [11:0] res;
   int          wait_c;
   // mux is read when the result lands, as the external switch would be
   assign res = chan == 3'h6 ? (monitor_mux_select_lsb ? iin : vin) : sense[chan];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_rsp <= '0;
         chan <= 3'h0;
         wait_c <= 0;
      end else begin
         adc_rsp.valid <= wait_c == 1;
         // stale data toggles so a late read of the bus never looks valid
         adc_rsp.data <= wait_c == 1 ? res : ~adc_rsp.data;
         wait_c <= adc_req.req ? 2 + 5 * adc_req.chan : (wait_c > 0 ? wait_c - 1 : 0);
         if (adc_req.req)
            chan <= adc_req.chan;
      end
   end
endmodule
`default_nettype wire

//--- test_current_and_input_protection.sv
// self-checking bench for the current and input protection block
`timescale 1ns/10ps
`default_nettype none
module test_current_and_input_protection;
   logic                  pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic                  fault_pin = 1'b0, pready, pslverr, fault_irq, monitor_mux_select_lsb, e;
   logic [11:0]           paddr = 12'h000, vin = 12'h800, iin = 12'h123;
   logic [31:0]           pwdata = 32'h0000_0000, prdata, q, t;
   logic [3:0]            quick_cmp_trip = 4'h0, rail_vout_low = 4'h0, quick_cmp_enable, foldback_active;
   logic [3:0]            soft_stop_req;
   logic [3:0][5:0]       quick_overcurrent_threshold;
   logic [5:0]            pulse_width_output_enable, sync_rectifier_enable;
   logic [5:0][7:0]       balance_adjust;
   logic [5:0][11:0]      sense = {12'h100, 12'h100, 12'h300, 12'h300, 12'h080, 12'h200};
   cip_pkg::cip_adc_req_t adc_req;
   cip_pkg::cip_adc_rsp_t adc_rsp;
   logic [11:0]           ra [9];
   logic [31:0]           rv [9], rm [9];
   int                    failures = 0, checked = 0, seed = 32'h98408cbb;

   always #25 pclk = ~pclk;
   cip_top dut (.clk_en(1'b1), .*);
   cip_adc_model adc (.*);

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n, 1, "wait states");
   endtask
   // bounded wait: a stage that never drops still ends the wait and is reported
   task automatic wait_off(input logic [5:0] m, input int lim);
      int n;
      n = 0;
      while ((pulse_width_output_enable & m) !== 6'h00 && n < lim) begin
         @(posedge pclk);
         n++;
      end
      repeat (4) @(posedge pclk);
      chk(pulse_width_output_enable & m, 0, "drive left on");
      chk(sync_rectifier_enable & m, 0, "rectifier left on");
   endtask
   function automatic logic [3:0] fold_exp(input logic [11:0] map, input logic [11:0] gain, input logic [15:0] lim);
      logic [31:0] sum;
      for (int r = 0; r < 4; r++) begin
         sum = 0;
         for (int s = 0; s < 6; s++)
            if (map[2*s+:2] == 2'(r))
               sum += (sense[s] * gain) >> 8;
         fold_exp[r] = sum > lim;
      end
   endfunction
   task automatic complete_run;
      $display("counts: %0d checked, %0d failures", checked, failures);
      if (failures == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge pclk);
      failures++;
      complete_run();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      #1;
      chk(balance_adjust, {6{8'h80}}, "adjust reset");
      chk(soft_stop_req, 4'hf, "lockout at reset");
      $display("test reset done");
      t = $random(seed);
      ra = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h01c, 12'h020, 12'h024};
      rv = '{32'h0000_126f, {14'h0000, t[17:12] | 6'h01, t[11:6] | 6'h01, t[5:0] | 6'h01}, 32'h0000_0e50,
             32'h0000_0100, 32'h0000_0000, 32'h0000_0400, 32'h0f00_0080, 32'h0200_0100, 32'h0100_0000};
      rm = '{32'h0000_3fff, 32'h00ff_ffff, 32'h0000_0fff, 32'h0000_0fff, 32'h0000_ffff, 32'h0000_ffff,
             32'h0fff_0fff, 32'h0fff_0fff, 32'h0fff_0000};
      for (int i = 0; i < 9; i++) begin
         apb(1'b1, ra[i], rv[i]);
         apb(1'b0, ra[i], 32'h0000_0000);
         chk({e, q}, {1'b0, rv[i] & rm[i]}, "readback");
      end
      apb(1'b1, 12'h038, 32'hffff_ffff);
      chk(e, 1'b1, "unmapped write");
      apb(1'b0, 12'h038, 32'h0000_0000);
      chk({e, q}, {1'b1, 32'h0000_0000}, "unmapped read");
      chk(quick_overcurrent_threshold, rv[1][23:0], "thresholds");
      chk(quick_cmp_enable, 4'b0111, "comparator enables");
      $display("test registers done");
      repeat (16 * 4000) @(posedge pclk);
      chk(soft_stop_req, 4'h0, "lockout release");
      chk(pulse_width_output_enable, 6'h3f, "stages running");
      chk(foldback_active, fold_exp(12'he50, 12'h100, 16'h0400), "foldback");
      chk(balance_adjust[0] < 8'h80 && balance_adjust[1] > 8'h80, 1, "balance direction");
      chk(balance_adjust[0] + balance_adjust[1], 16'h0100, "balance total");
      apb(1'b0, 12'h034, 32'h0000_0000);
      chk(q, {4'h0, iin, 4'h0, vin}, "input monitor");
      $display("test balance and foldback done");
      rail_vout_low <= 4'b0010;
      wait_off(6'b001100, 16500);
      quick_cmp_trip <= 4'b1100;
      wait_off(6'b010000, 10);
      chk(pulse_width_output_enable[5], 1'b1, "disabled comparator");
      quick_cmp_trip <= 4'b0000;
      $display("test comparators done");
      apb(1'b1, 12'h000, 32'h0000_127f);
      fault_pin <= 1'b1;
      repeat (20) @(posedge pclk);
      fault_pin <= 1'b0;
      chk({fault_irq, pulse_width_output_enable[1:0]}, 3'b011, "sequencing pin");
      apb(1'b1, 12'h000, 32'h0000_126f);
      fault_pin <= 1'b1;
      wait_off(6'b000011, 280);
      chk(fault_irq, 1'b1, "fault interrupt");
      fault_pin <= 1'b0;
      $display("test fault pin done");
      vin <= 12'h040;
      wait_off(6'h3f, 12100);
      chk(soft_stop_req, 4'hf, "soft stop");
      $display("test input lockout done");
      complete_run();
   end
endmodule
`default_nettype wire
